// file: rtl/cwk_map.svh
`ifndef CWK_MAP_SVH
`define CWK_MAP_SVH
// timing counts in 10 ns clock cycles
`define CWK_FILTER_CYC 16'd50
`define CWK_TIMEOUT_CYC 24'd115000
`define CWK_TOGGLE_HALF_CYC 16'd500
`define CWK_PRESTABLE_CYC 16'd500
`define CWK_INVALID_CYC0 16'd100
`define CWK_INVALID_CYC1 16'd200
`define CWK_INVALID_CYC2 16'd500
`define CWK_INVALID_CYC3 16'd1000
`define CWK_MIN_CYC0 16'd200
`define CWK_MIN_CYC1 16'd400
`define CWK_MIN_CYC2 16'd1000
`define CWK_MIN_CYC3 16'd2000
`define CWK_MAX_CYC 16'd5000
// field codes
`define CWK_EDGE_BOTH 2'h0
`define CWK_EDGE_RISE 2'h1
`define CWK_EDGE_FALL 2'h2
`define CWK_EDGE_PULSE 2'h3
`define CWK_STAT_NONE 2'h0
`define CWK_STAT_RISE 2'h1
`define CWK_STAT_FALL 2'h2
`endif

// file: rtl/cwk_pkg.sv
package cwk_pkg;
  typedef enum logic [1:0] {
    CWK_MODE_SLEEP = 2'h0,
    CWK_MODE_STANDBY = 2'h1,
    CWK_MODE_NORMAL = 2'h2,
    CWK_MODE_LISTEN = 2'h3
  } cwk_mode_t;
  typedef enum logic [1:0] {
    CWK_BUS_IDLE = 2'h0,
    CWK_BUS_DOM1 = 2'h1,
    CWK_BUS_REC = 2'h2,
    CWK_BUS_WAITREC = 2'h3
  } cwk_bus_t;
  typedef struct packed {
    logic [1:0] edge_cfg;
    logic [1:0] width_sel;
    logic rxd_toggle;
    logic pol_rise;
    logic max_disable;
  } cwk_cfg_t;
endpackage : cwk_pkg

// file: rtl/cwk_wake.sv
// Operation
// - wake pattern: dominant, recessive, dominant, filtered
// - unfiltered activity never resets pattern monitor
// - second dominant completes pattern, starts request
// - phase qualifies only beyond filter time
// - timeout discards progress, waits for recessive
// - bus wake in sleep: standby, interrupt
// - behaviour bit 0: receive pin held low
// - behaviour bit 1: toggle with 10us period
// - normal mode or undervoltage cancels request
// - request active after power up, wake from sleep
// - wake edge: both, rising or falling
// - single edge in sleep needs prestable level, either value
// - pulses below invalid width discarded
// - pulse valid between min and max width
// - max disable turns pulse into filtered
// - polarity bit picks pulse direction
// - pin edge status latched until cleared
// - local wake outside normal and listen, goes standby
// - selective wake: no bus data, listed sources
// - wake event other than frame overflow sets flag, interrupt, rxd low
// - selective wake needs configured, no error, enable
// - frame overflow clears selective wake enable
`include "cwk_map.svh"
module cwk_wake
  import cwk_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic bus_dominant_i,
  input wire logic wake_pin_i,
  input wire logic bus_rx_data_i,
  input wire cwk_cfg_t cfg_i,
  input wire logic mode_wr_i,
  input wire cwk_mode_t mode_wdata_i,
  input wire logic vcc_uv_i,
  input wire logic irq_enable_i,
  input wire logic wake_stat_clr_i,
  input wire logic flags_clr_i,
  input wire logic selwake_configured_i,
  input wire logic selwake_error_i,
  input wire logic selwake_enable_set_i,
  input wire logic wake_match_frame_i,
  input wire logic frame_overflow_flag_i,
  output logic rxd_o,
  output logic host_irq_n_o,
  output logic host_supply_enable_o,
  output cwk_mode_t mode_o,
  output logic bus_wake_rxd_request_o,
  output logic local_pin_wake_o,
  output logic bus_wake_pattern_o,
  output logic wake_frame_flag_o,
  output logic selwake_enable_o,
  output logic selwake_active_o,
  output logic [1:0] wake_edge_stat_o
);
  // synchronisers, change accepted when stages two and three agree
  logic [2:0] bus_sync_r, pin_sync_r;
  logic bus_s_r, pin_s_r, pin_prev_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_sync_r <= 3'h0;
      pin_sync_r <= 3'h0;
      bus_s_r <= 1'b0;
      pin_s_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      bus_sync_r <= {bus_sync_r[1:0], bus_dominant_i};
      pin_sync_r <= {pin_sync_r[1:0], wake_pin_i};
      if (bus_sync_r[1] == bus_sync_r[2]) bus_s_r <= bus_sync_r[2];
      if (pin_sync_r[1] == pin_sync_r[2]) pin_s_r <= pin_sync_r[2];
      pin_prev_r <= pin_s_r;
    end
  end

  // saturating 16-bit increment
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  // normal and listen both hand the receiver to the host
  function automatic logic is_online(input cwk_mode_t m);
    is_online = (m == CWK_MODE_NORMAL) || (m == CWK_MODE_LISTEN);
  endfunction : is_online

  // mode write towards the given target in this cycle
  function automatic logic wr_to(input logic wr, input cwk_mode_t d, input cwk_mode_t m);
    wr_to = wr && (d == m);
  endfunction : wr_to

  cwk_mode_t mode_r;
  logic sleepish, wake_any, bus_wake_done, lwu_evt, sw_act;
  assign sleepish = (mode_r == CWK_MODE_SLEEP);

  // bus phase length counter, restarts on every bus change
  logic [15:0] phase_cnt_r;
  logic bus_prev_r;
  logic filt_dom, filt_rec;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_cnt_r <= 16'h0;
      bus_prev_r <= 1'b0;
    end else begin
      bus_prev_r <= bus_s_r;
      phase_cnt_r <= (bus_s_r != bus_prev_r) ? 16'h0 : sat_inc(phase_cnt_r);
    end
  end
  assign filt_dom = bus_s_r && (bus_s_r == bus_prev_r) && (phase_cnt_r == `CWK_FILTER_CYC);
  assign filt_rec = !bus_s_r && (bus_s_r == bus_prev_r) && (phase_cnt_r == `CWK_FILTER_CYC);

  // pattern monitor with timeout
  cwk_bus_t bus_st_r;
  logic [23:0] to_cnt_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_st_r <= CWK_BUS_IDLE;
      to_cnt_r <= 24'h0;
    end else if (!sleepish) begin
      bus_st_r <= CWK_BUS_IDLE;
      to_cnt_r <= 24'h0;
    end else begin
      to_cnt_r <= (bus_st_r == CWK_BUS_IDLE || bus_st_r == CWK_BUS_WAITREC) ? 24'h0 : to_cnt_r + 24'h1;
      unique case (bus_st_r)
        CWK_BUS_IDLE: begin
          if (filt_dom) bus_st_r <= CWK_BUS_DOM1;
        end
        CWK_BUS_DOM1: begin
          if (to_cnt_r >= `CWK_TIMEOUT_CYC) bus_st_r <= CWK_BUS_WAITREC;
          else if (filt_rec) bus_st_r <= CWK_BUS_REC;
        end
        CWK_BUS_REC: begin
          if (to_cnt_r >= `CWK_TIMEOUT_CYC) bus_st_r <= CWK_BUS_WAITREC;
          else if (filt_dom) bus_st_r <= CWK_BUS_IDLE;
        end
        CWK_BUS_WAITREC: begin
          if (filt_rec) bus_st_r <= CWK_BUS_IDLE;
        end
      endcase
    end
  end
  assign bus_wake_done = sleepish && !sw_act && (bus_st_r == CWK_BUS_REC) && filt_dom
    && (to_cnt_r < `CWK_TIMEOUT_CYC);

  // local wake pin detection
  logic [15:0] lvl_cnt_r;
  logic armed_r, pin_edge, rise, fall, edge_ok, pulse_ok, width_ok;
  logic [15:0] inv_w, min_w;
  assign rise = pin_s_r && !pin_prev_r;
  assign fall = !pin_s_r && pin_prev_r;
  assign pin_edge = rise || fall;
  always_comb begin
    unique case (cfg_i.width_sel)
      2'h0: begin inv_w = `CWK_INVALID_CYC0; min_w = `CWK_MIN_CYC0; end
      2'h1: begin inv_w = `CWK_INVALID_CYC1; min_w = `CWK_MIN_CYC1; end
      2'h2: begin inv_w = `CWK_INVALID_CYC2; min_w = `CWK_MIN_CYC2; end
      2'h3: begin inv_w = `CWK_INVALID_CYC3; min_w = `CWK_MIN_CYC3; end
    endcase
  end
  // level age counter and arming after sleep entry
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_cnt_r <= 16'h0;
      armed_r <= 1'b0;
    end else begin
      lvl_cnt_r <= pin_edge ? 16'h0 : sat_inc(lvl_cnt_r);
      if (!sleepish) begin
        armed_r <= 1'b0;
      end else if (lvl_cnt_r >= `CWK_PRESTABLE_CYC) begin
        armed_r <= 1'b1;
      end
    end
  end
  always_comb begin
    unique case (cfg_i.edge_cfg)
      `CWK_EDGE_BOTH: edge_ok = pin_edge;
      `CWK_EDGE_RISE: edge_ok = rise && (armed_r || !sleepish);
      `CWK_EDGE_FALL: edge_ok = fall && (armed_r || !sleepish);
      default: edge_ok = 1'b0;
    endcase
  end
  // pulse mode: trailing edge ends pulse of the chosen polarity
  logic trail;
  assign trail = cfg_i.pol_rise ? fall : rise;
  assign width_ok = (lvl_cnt_r >= min_w) && (lvl_cnt_r >= inv_w);
  assign pulse_ok = trail && width_ok && (cfg_i.max_disable || lvl_cnt_r <= `CWK_MAX_CYC);
  logic filt_ok;
  assign filt_ok = cfg_i.max_disable && (pin_s_r == cfg_i.pol_rise) && (lvl_cnt_r == min_w);
  assign lwu_evt = !is_online(mode_r)
    && ((cfg_i.edge_cfg == `CWK_EDGE_PULSE) ? (cfg_i.max_disable ? filt_ok : pulse_ok) : edge_ok);

  // edge status latch, set wins over clear
  logic [1:0] stat_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_r <= `CWK_STAT_NONE;
    end else if (rise) begin
      stat_r <= `CWK_STAT_RISE;
    end else if (fall) begin
      stat_r <= `CWK_STAT_FALL;
    end else if (wake_stat_clr_i) begin
      stat_r <= `CWK_STAT_NONE;
    end
  end

  // selective wake enable and entry gate
  logic selwake_enable_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      selwake_enable_r <= 1'b0;
    end else if (frame_overflow_flag_i) begin
      selwake_enable_r <= 1'b0;
    end else if (selwake_enable_set_i) begin
      selwake_enable_r <= 1'b1;
    end
  end
  assign sw_act = sleepish && selwake_enable_r && selwake_configured_i && !selwake_error_i;

  // mode control
  assign wake_any = sleepish && (bus_wake_done || lwu_evt
    || (sw_act && (wake_match_frame_i || frame_overflow_flag_i)));
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_r <= CWK_MODE_STANDBY;
    end else if (mode_wr_i) begin
      mode_r <= mode_wdata_i;
    end else if (wake_any) begin
      mode_r <= CWK_MODE_STANDBY;
    end
  end

  // wake flags, set wins over clear
  logic bwp_r, lwu_r, wuf_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bwp_r <= 1'b0;
      lwu_r <= 1'b0;
      wuf_r <= 1'b0;
    end else begin
      bwp_r <= bus_wake_done || (bwp_r && !flags_clr_i);
      lwu_r <= lwu_evt || (lwu_r && !flags_clr_i);
      wuf_r <= (sw_act && wake_match_frame_i) || (wuf_r && !flags_clr_i);
    end
  end

  // bus wake request: active from power up, set by wakes, dropped by normal or uv
  logic req_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_r <= 1'b1;
    end else if (vcc_uv_i || wr_to(mode_wr_i, mode_wdata_i, CWK_MODE_NORMAL)) begin
      req_r <= 1'b0;
    end else if (wr_to(mode_wr_i, mode_wdata_i, CWK_MODE_LISTEN)) begin
      req_r <= 1'b0;
    end else if (wake_any) begin
      req_r <= 1'b1;
    end else if (wr_to(mode_wr_i, mode_wdata_i, CWK_MODE_STANDBY)) begin
      req_r <= 1'b0;
    end
  end

  // toggle divider for the receive pin
  logic [15:0] tog_cnt_r;
  logic tog_r;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tog_cnt_r <= 16'h0;
      tog_r <= 1'b0;
    end else if (!req_r) begin
      tog_cnt_r <= 16'h0;
      tog_r <= 1'b0;
    end else if (tog_cnt_r == `CWK_TOGGLE_HALF_CYC - 16'h1) begin
      tog_cnt_r <= 16'h0;
      tog_r <= ~tog_r;
    end else begin
      tog_cnt_r <= tog_cnt_r + 16'h1;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxd_o <= 1'b1;
      host_irq_n_o <= 1'b1;
      host_supply_enable_o <= 1'b1;
      selwake_active_o <= 1'b0;
    end else begin
      selwake_active_o <= sw_act;
      if (is_online(mode_r)) rxd_o <= bus_rx_data_i;
      else if (req_r) rxd_o <= cfg_i.rxd_toggle ? tog_r : 1'b0;
      else rxd_o <= 1'b1;
      host_irq_n_o <= !(irq_enable_i && (bwp_r || lwu_r || wuf_r));
      host_supply_enable_o <= !sleepish;
    end
  end
  assign mode_o = mode_r;
  assign bus_wake_rxd_request_o = req_r;
  assign local_pin_wake_o = lwu_r;
  assign bus_wake_pattern_o = bwp_r;
  assign wake_frame_flag_o = wuf_r;
  assign selwake_enable_o = selwake_enable_r;
  assign wake_edge_stat_o = stat_r;
endmodule : cwk_wake

// file: bench/cwk_wake_assertions.sv
module cwk_wake_chk
  import cwk_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic bus_dominant_i,
  input wire logic mode_wr_i,
  input wire cwk_mode_t mode_wdata_i,
  input wire logic vcc_uv_i,
  input wire logic irq_enable_i,
  input wire logic frame_overflow_flag_i,
  input wire logic selwake_configured_i,
  input wire logic selwake_error_i,
  input wire cwk_cfg_t cfg_i,
  input wire logic rxd_o,
  input wire logic host_irq_n_o,
  input wire cwk_mode_t mode_o,
  input wire logic bus_wake_rxd_request_o,
  input wire logic bus_wake_pattern_o,
  input wire logic selwake_enable_o,
  input wire logic selwake_active_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_uv_cancel: assert property (vcc_uv_i |=> !bus_wake_rxd_request_o)
    else $error("uv kept request");
  chk_normal_cancel: assert property (mode_wr_i && mode_wdata_i == CWK_MODE_NORMAL |=>
    mode_o == CWK_MODE_NORMAL && !bus_wake_rxd_request_o) else $error("normal kept request");
  chk_steady_low: assert property (!$past(sys_rst_i) && !$past(cfg_i.rxd_toggle) &&
    $past(bus_wake_rxd_request_o) && bus_wake_rxd_request_o |-> !rxd_o) else $error("rxd not low");
  chk_toggle_hold: assert property ($fell(rxd_o) && bus_wake_rxd_request_o && cfg_i.rxd_toggle
    |-> (!rxd_o) [*8]) else $error("toggle too fast");
  chk_pattern_dominant: assert property ($rose(bus_wake_pattern_o) |->
    $past(bus_dominant_i, 8) && $past(bus_dominant_i, 40)) else $error("wake without dominant");
  chk_wake_standby: assert property ($rose(bus_wake_pattern_o) |->
    mode_o == CWK_MODE_STANDBY && bus_wake_rxd_request_o) else $error("wake without standby");
  chk_wake_irq: assert property ($rose(bus_wake_pattern_o) && irq_enable_i |-> ##[0:2] !host_irq_n_o)
    else $error("wake without irq");
  chk_selwake_entry: assert property (selwake_active_o |-> $past(selwake_configured_i) &&
    !$past(selwake_error_i) && $past(selwake_enable_o)) else $error("selwake entered early");
  chk_ovf_disable: assert property (frame_overflow_flag_i |=> !selwake_enable_o)
    else $error("overflow kept enable");
endmodule : cwk_wake_chk
bind cwk_wake cwk_wake_chk cwk_wake_chk_inst (.*);

// file: bench/cwk_host_model.sv
module cwk_host_model
  import cwk_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rxd_i,
  input wire logic arm_i,
  input wire logic tb_wr_i,
  input wire cwk_mode_t tb_mode_i,
  output logic mode_wr_o,
  output cwk_mode_t mode_wdata_o
);
  logic last_r = 1'b1;
  logic auto_r = 1'b0;
  // falling receive line asks for normal mode
  always_ff @(posedge ref_clk_i) begin
    last_r <= rxd_i;
    auto_r <= arm_i && last_r && !rxd_i;
  end
  // own answer overrides bench writes
  assign mode_wr_o = tb_wr_i || auto_r;
  assign mode_wdata_o = auto_r ? CWK_MODE_NORMAL : tb_mode_i;
endmodule : cwk_host_model

// file: bench/cwk_wake_tb_top.sv
module cwk_wake_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cwk_pkg::*;
  logic sys_rst_i = 1'b1, bus_rx_data_i = 1'b1, irq_enable_i = 1'b1, ref_clk_i = 1'b0, bus_dominant_i = 1'b0;
  logic wake_pin_i = 1'b0, vcc_uv_i = 1'b0, wake_stat_clr_i = 1'b0, flags_clr_i = 1'b0, tb_wr = 1'b0, arm = 1'b0;
  logic selwake_configured_i = 1'b0, selwake_error_i = 1'b0, selwake_enable_set_i = 1'b0;
  logic wake_match_frame_i = 1'b0, frame_overflow_flag_i = 1'b0, mode_wr_i;
  logic rxd_o, host_irq_n_o, host_supply_enable_o, bus_wake_rxd_request_o, local_pin_wake_o;
  logic bus_wake_pattern_o, wake_frame_flag_o, selwake_enable_o, selwake_active_o;
  logic [1:0] wake_edge_stat_o;
  cwk_mode_t tb_mode = CWK_MODE_SLEEP, mode_wdata_i, mode_o;
  cwk_cfg_t cfg_i = '0;
  int num_errors = 0, tests_run = 0;
  // free running clock
  always #5 ref_clk_i = ~ref_clk_i;
  cwk_wake cwk_wake_inst (.*);
  cwk_host_model cwk_host_model_inst (.ref_clk_i(ref_clk_i), .rxd_i(rxd_o), .arm_i(arm), .tb_wr_i(tb_wr),
    .tb_mode_i(tb_mode), .mode_wr_o(mode_wr_i), .mode_wdata_o(mode_wdata_i));
  task chk(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task tk(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tk
  task wr(cwk_mode_t m);
    tb_mode = m;
    tb_wr = 1'b1;
    tk(1);
    tb_wr = 1'b0;
    tk(2);
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    tk(1);
    s = 1'b0;
    tk(2);
  endtask : pulse
  task run(int t[$]);
    foreach (t[i]) begin
      bus_dominant_i = !i[0];
      tk(t[i]);
    end
  endtask : run
  task stay(logic v, output int n);
    n = 0;
    while (rxd_o === v && n < 2000) begin
      tk(1);
      n++;
    end
  endtask : stay
  task t_reset_uv;
    chk({mode_o, bus_wake_rxd_request_o, rxd_o}, 8'h06);
    pulse(vcc_uv_i);
    chk({bus_wake_rxd_request_o, rxd_o}, 8'h01);
    $display("reset test done");
  endtask : t_reset_uv
  task t_bus_wake;
    wr(CWK_MODE_SLEEP);
    run({30, 30, 30, 30});
    chk({mode_o, bus_wake_pattern_o}, 8'h00);
    run({70, 20, 20, 70, 20, 20, 70, 5});
    chk({mode_o, bus_wake_pattern_o, host_irq_n_o, rxd_o}, 8'h0C);
    wr(CWK_MODE_NORMAL);
    chk(bus_wake_rxd_request_o, 8'h00);
    wr(CWK_MODE_SLEEP);
    arm = 1'b1;
    run({70, 70, 70, 10});
    arm = 1'b0;
    chk({mode_o, bus_wake_rxd_request_o}, 8'h04);
    $display("bus wake test done");
  endtask : t_bus_wake
  task t_toggle;
    int n;
    cfg_i.rxd_toggle = 1'b1;
    wr(CWK_MODE_SLEEP);
    run({70, 70, 70, 5});
    stay(1'b0, n);
    stay(1'b1, n);
    chk(n == 500, 8'h01);
    stay(1'b0, n);
    chk(n == 500, 8'h01);
    wr(CWK_MODE_LISTEN);
    chk(bus_wake_rxd_request_o, 8'h00);
    cfg_i.rxd_toggle = 1'b0;
    $display("toggle test done");
  endtask : t_toggle
  task t_local;
    wr(CWK_MODE_SLEEP);
    wake_pin_i = 1'b1;
    tk(10);
    chk({mode_o, local_pin_wake_o, bus_wake_rxd_request_o, wake_edge_stat_o}, 8'h1D);
    pulse(wake_stat_clr_i);
    chk(wake_edge_stat_o, 8'h00);
    wr(CWK_MODE_NORMAL);
    pulse(flags_clr_i);
    wake_pin_i = 1'b0;
    tk(10);
    chk({mode_o, local_pin_wake_o}, 8'h04);
    $display("local wake test done");
  endtask : t_local
  task t_sel;
    wr(CWK_MODE_SLEEP);
    selwake_configured_i = 1'b1;
    selwake_error_i = 1'b1;
    pulse(selwake_enable_set_i);
    chk(selwake_active_o, 8'h00);
    chk(host_supply_enable_o, 8'h00);
    selwake_error_i = 1'b0;
    pulse(selwake_enable_set_i);
    chk({selwake_enable_o, selwake_active_o}, 8'h03);
    pulse(wake_match_frame_i);
    chk({mode_o, wake_frame_flag_o, host_supply_enable_o}, 8'h07);
    wr(CWK_MODE_SLEEP);
    pulse(frame_overflow_flag_i);
    chk({mode_o, selwake_enable_o}, 8'h02);
    $display("selective wake test done");
  endtask : t_sel
  task give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // reset, then the scenarios in turn
  initial begin
    tk(5);
    sys_rst_i = 1'b0;
    tk(2);
    t_reset_uv;
    t_bus_wake;
    t_toggle;
    t_local;
    t_sel;
    give_verdict;
  end
  // watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    give_verdict;
  end
endmodule : cwk_wake_tb_top
